/* ethernet_stats_counters.sv */
// Statistics counter bank for the MAC receive and transmit paths
// Notes on behaviour
// - Count good receive frames 512 to 1023
// - Count good receive frames 1024 to 1518
// - Count good receive frames above 1518
// - Filtered or overflowed frames skip receive bins
// - Count rising edges of receive idle
// - Accumulate receive idle time in microseconds
// - Idle counters cleared while efficiency enable low
// - Idle counters run in normal and sleep states
// - Count bad or forced bad checksum frames
// - Flag deferral over two frames plus 16
// - Deferral timer restarts for every deferral
// - Count frames with carrier absence or loss
// - Accumulate bytes of errored transmissions
// - Count single and multiple collision successes
// - Sixteen collisions abort frame and count
// - Count frames aborted by late collision
// - Byte totals per address type, good frames, not flow control
// - Frame counts per address type, good frames, not flow control
// - Count successfully sent pause frames
// - Count good 64 byte frames, not flow control
// - Count good transmit frames 65 to 511 binned
`timescale 1ns/10ps
`default_nettype none

module ethernet_stats_counters
  import stats_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire rx_stat_t    RX_STAT,
  input  wire tx_stat_t    TX_STAT,
  input  wire logic        RX_LPI,
  input  wire logic        EEE_EN,
  input  wire pwr_t        POWER_STATE,
  input  wire logic        FORCE_BAD_CRC,
  input  wire logic [13:0] MAX_SIZE,
  input  wire logic        TX_DEFER,
  input  wire logic        BYTE_TICK,
  input  wire logic        TX_COLLISION,
  output var  stats_t      STATS,
  output var  logic        TX_ABORT
);

  state_t      q;
  state_t      d;
  logic        rx_ok;
  logic        pwr_ok;
  logic        tx_err;
  logic        tx_good;
  logic [15:0] defer_thr;

  // Qualifiers for the frame reports
  assign rx_ok = RX_STAT.done & RX_STAT.good
               & ~RX_STAT.filter_fail & ~RX_STAT.overflow;
  assign pwr_ok = (POWER_STATE != PWR_OTHER);
  assign tx_err = TX_STAT.fcs_bad | FORCE_BAD_CRC
                | TX_STAT.carrier_err | TX_STAT.late_col
                | (q.col_cnt == COL_LIMIT);
  assign tx_good = TX_STAT.done & ~TX_STAT.partial & ~tx_err;
  assign defer_thr = {1'b0, MAX_SIZE, 1'b0} + DEFER_MARGIN;

  // Next state: frame counters add one, byte counters add the length, each of its own width, and wrap
  always_comb
  begin
    d = q;
    d.abort = 1'b0;
    // Receive length bins
    if (rx_ok)
    begin
      if (RX_STAT.len >= LEN_512 && RX_STAT.len <= LEN_1023)
        d.cnt.rx_512_1023 = q.cnt.rx_512_1023 + 20'h1;
      if (RX_STAT.len >= LEN_1024 && RX_STAT.len <= LEN_1518)
        d.cnt.rx_1024_1518 = q.cnt.rx_1024_1518 + 20'h1;
      if (RX_STAT.len > LEN_1518)
        d.cnt.rx_gt_1518 = q.cnt.rx_gt_1518 + 20'h1;
    end
    // Receive low power idle, held clear while disabled
    d.lpi_prev = RX_LPI;
    if (!EEE_EN)
    begin
      d.cnt.rx_lpi_trans = '0;
      d.cnt.rx_lpi_time = '0;
      d.us_div = '0;
    end
    else if (pwr_ok)
    begin
      if (RX_LPI && !q.lpi_prev)
        d.cnt.rx_lpi_trans = q.cnt.rx_lpi_trans + 32'h1;
      if (RX_LPI)
      begin
        if (q.us_div == US_LAST)
        begin
          d.us_div = '0;
          d.cnt.rx_lpi_time = q.cnt.rx_lpi_time + 32'h1;
        end
        else
          d.us_div = q.us_div + 8'h1;
      end
    end
    // Transmit frame end clears per frame tracking first
    if (TX_STAT.done && !TX_STAT.partial)
    begin
      d.col_cnt = '0;
      d.defer_hit = 1'b0;
    end
    // Deferral timer in byte times, zero outside a deferral
    if (!TX_DEFER)
      d.defer_cnt = '0;
    else if (BYTE_TICK && q.defer_cnt != DEFER_MAX)
    begin
      d.defer_cnt = q.defer_cnt + 16'h1;
      if (q.defer_cnt == defer_thr && !q.defer_hit)
      begin
        d.defer_hit = 1'b1;
        d.cnt.tx_excess_defer = q.cnt.tx_excess_defer + 20'h1;
      end
    end
    // Collision tally and abort on the sixteenth
    if (TX_COLLISION && q.col_cnt < COL_LIMIT)
    begin
      d.col_cnt = q.col_cnt + 5'h1;
      if (q.col_cnt == COL_LIMIT - 5'h1)
      begin
        d.abort = 1'b1;
        d.cnt.tx_excess_col = q.cnt.tx_excess_col + 20'h1;
      end
    end
    // Transmit error counters
    if (TX_STAT.done)
    begin
      if (TX_STAT.fcs_bad || FORCE_BAD_CRC)
        d.cnt.tx_fcs_err = q.cnt.tx_fcs_err + 20'h1;
      if (TX_STAT.carrier_err)
        d.cnt.tx_carrier_err = q.cnt.tx_carrier_err + 20'h1;
      if (TX_STAT.late_col)
        d.cnt.tx_late_col = q.cnt.tx_late_col + 20'h1;
      if (tx_err)
        d.cnt.tx_bad_bytes = q.cnt.tx_bad_bytes
                           + {18'h0, TX_STAT.len};
    end
    // Successful transmit counters
    if (tx_good)
    begin
      if (q.col_cnt == 5'h1)
        d.cnt.tx_single_col = q.cnt.tx_single_col + 20'h1;
      if (q.col_cnt > 5'h1)
        d.cnt.tx_multi_col = q.cnt.tx_multi_col + 20'h1;
      if (TX_STAT.pause)
        d.cnt.tx_pause = q.cnt.tx_pause + 20'h1;
      if (!TX_STAT.flow_ctrl)
      begin
        case (TX_STAT.addr)
          ADDR_UCAST:
          begin
            d.cnt.tx_ucast_bytes = q.cnt.tx_ucast_bytes
                                 + {18'h0, TX_STAT.len};
            d.cnt.tx_ucast = q.cnt.tx_ucast + 20'h1;
          end
          ADDR_BCAST:
          begin
            d.cnt.tx_bcast_bytes = q.cnt.tx_bcast_bytes
                                 + {18'h0, TX_STAT.len};
            d.cnt.tx_bcast = q.cnt.tx_bcast + 20'h1;
          end
          ADDR_MCAST:
          begin
            d.cnt.tx_mcast_bytes = q.cnt.tx_mcast_bytes
                                 + {18'h0, TX_STAT.len};
            d.cnt.tx_mcast = q.cnt.tx_mcast + 20'h1;
          end
          default:
          begin
            d.cnt.tx_ucast = q.cnt.tx_ucast;
          end
        endcase
        if (TX_STAT.len == LEN_64)
          d.cnt.tx_64 = q.cnt.tx_64 + 20'h1;
      end
      if (TX_STAT.len >= LEN_65 && TX_STAT.len <= LEN_127)
        d.cnt.tx_65_127 = q.cnt.tx_65_127 + 20'h1;
      if (TX_STAT.len >= LEN_128 && TX_STAT.len <= LEN_255)
        d.cnt.tx_128_255 = q.cnt.tx_128_255 + 20'h1;
      if (TX_STAT.len >= LEN_256 && TX_STAT.len <= LEN_511)
        d.cnt.tx_256_511 = q.cnt.tx_256_511 + 20'h1;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      q <= '0;
    else
      q <= d;
  end

  // Outputs straight from flip-flops
  assign STATS = q.cnt;
  assign TX_ABORT = q.abort;

  // Checks on counter behaviour
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_rx_bin_mid: assert property (
    rx_ok && RX_STAT.len >= LEN_512 && RX_STAT.len <= LEN_1023
    |=> STATS.rx_512_1023 == 20'($past(STATS.rx_512_1023) + 1))
    else $error("mid receive bin missed a frame");

  a_rx_bin_top: assert property (
    rx_ok && RX_STAT.len == LEN_1518
    |=> STATS.rx_1024_1518 == 20'($past(STATS.rx_1024_1518) + 1)
        && $stable(STATS.rx_gt_1518))
    else $error("1518 byte frame counted in wrong bin");

  a_rx_bin_filter: assert property (
    RX_STAT.done && (RX_STAT.filter_fail || RX_STAT.overflow)
    |=> $stable(STATS.rx_gt_1518) && $stable(STATS.rx_512_1023))
    else $error("rejected frame reached a receive bin");

  a_lpi_edge: assert property (
    EEE_EN && pwr_ok && RX_LPI && !q.lpi_prev
    |=> STATS.rx_lpi_trans == 32'($past(STATS.rx_lpi_trans) + 1))
    else $error("idle transition not counted");

  a_lpi_time_tick: assert property (
    EEE_EN && pwr_ok && RX_LPI && q.us_div == US_LAST
    |=> STATS.rx_lpi_time == 32'($past(STATS.rx_lpi_time) + 1)
        && q.us_div == 8'h0)
    else $error("idle time missed a microsecond");

  a_lpi_held_clear: assert property (
    !EEE_EN |=> STATS.rx_lpi_trans == 32'h0
                && STATS.rx_lpi_time == 32'h0)
    else $error("idle counters not held clear");

  a_fcs_forced: assert property (
    TX_STAT.done && FORCE_BAD_CRC
    |=> STATS.tx_fcs_err == 20'($past(STATS.tx_fcs_err) + 1))
    else $error("forced bad checksum frame not counted");

  a_defer_restart: assert property (
    !TX_DEFER |=> q.defer_cnt == 16'h0)
    else $error("deferral timer kept time across deferrals");

  a_col_abort: assert property (
    TX_COLLISION && q.col_cnt == 5'hf
    |=> TX_ABORT ##1 !TX_ABORT)
    else $error("sixteenth collision did not abort");

  a_ucast_bytes: assert property (
    tx_good && !TX_STAT.flow_ctrl && TX_STAT.addr == ADDR_UCAST
    |=> STATS.tx_ucast_bytes
        == $past(STATS.tx_ucast_bytes) + 32'($past(TX_STAT.len)))
    else $error("unicast byte total wrong");

  a_counter_wrap: assert property (
    rx_ok && RX_STAT.len > LEN_1518 && STATS.rx_gt_1518 == 20'hfffff
    |=> STATS.rx_gt_1518 == 20'h0)
    else $error("counter did not wrap to zero");

  a_rx_bin_high: assert property (
    rx_ok && RX_STAT.len > LEN_1518
    |=> STATS.rx_gt_1518 == 20'($past(STATS.rx_gt_1518) + 1))
    else $error("long receive frame not counted");

  a_lpi_sleep_edge: assert property (
    EEE_EN && POWER_STATE inside {PWR_SLEEP0, PWR_SLEEP3}
    && RX_LPI && !q.lpi_prev
    |=> STATS.rx_lpi_trans == 32'($past(STATS.rx_lpi_trans) + 1))
    else $error("idle transition lost in a sleep state");

  a_defer_excess: assert property (
    TX_DEFER && BYTE_TICK && !q.defer_hit && q.defer_cnt == defer_thr
    |=> STATS.tx_excess_defer
        == 20'($past(STATS.tx_excess_defer) + 1))
    else $error("excess deferral not counted");

  a_carrier_err: assert property (
    TX_STAT.done && TX_STAT.carrier_err
    |=> STATS.tx_carrier_err == 20'($past(STATS.tx_carrier_err) + 1))
    else $error("carrier error not counted");

  a_bad_bytes: assert property (
    TX_STAT.done && (TX_STAT.carrier_err || TX_STAT.late_col)
    |=> STATS.tx_bad_bytes
        == $past(STATS.tx_bad_bytes) + 32'($past(TX_STAT.len)))
    else $error("errored bytes not accumulated");

  a_single_col: assert property (
    tx_good && q.col_cnt == 5'h1
    |=> STATS.tx_single_col == 20'($past(STATS.tx_single_col) + 1))
    else $error("single collision success not counted");

  a_late_col: assert property (
    TX_STAT.done && TX_STAT.late_col
    |=> STATS.tx_late_col == 20'($past(STATS.tx_late_col) + 1))
    else $error("late collision abort not counted");

  a_pause_sent: assert property (
    tx_good && TX_STAT.pause
    |=> STATS.tx_pause == 20'($past(STATS.tx_pause) + 1))
    else $error("sent pause frame not counted");

  a_len_excluded: assert property (
    TX_STAT.done && (TX_STAT.partial || TX_STAT.flow_ctrl)
    |=> $stable(STATS.tx_64))
    else $error("excluded frame reached the 64 byte bin");

  a_partial_skip: assert property (
    TX_STAT.done && TX_STAT.partial
    |=> $stable(STATS.tx_65_127) && $stable(STATS.tx_128_255)
        && $stable(STATS.tx_256_511))
    else $error("partial attempt reached a length bin");

  c_rx_bin: cover property (rx_ok && RX_STAT.len > LEN_1518);
  c_abort: cover property (TX_ABORT);
  c_lpi_us: cover property (EEE_EN && RX_LPI && q.us_div == US_LAST);
  c_defer: cover property ($rose(q.defer_hit));
  c_partial: cover property (TX_STAT.done && TX_STAT.partial);

endmodule // ethernet_stats_counters

`default_nettype wire

/* ethernet_stats_counters_tb.sv */
// Self-checking bench for the statistics counter bank
`timescale 1ns/10ps
`default_nettype none

module ethernet_stats_counters_tb
  import stats_pkg::*;
;
  localparam int W = $bits(stats_t);
  logic CORE_CLK, RST, RX_LPI, EEE_EN, FORCE_BAD_CRC, TX_DEFER;
  logic BYTE_TICK, TX_COLLISION, TX_ABORT;
  rx_stat_t RX_STAT;
  tx_stat_t TX_STAT;
  pwr_t POWER_STATE;
  logic [13:0] MAX_SIZE;
  stats_t STATS, e, prev, cur, last, q[$];
  tx_stat_t t;
  int n_fail, compares, cycles, seed;
  logic [13:0] lens [6] = '{14'h01ff, LEN_512, LEN_1023, LEN_1024,
                            LEN_1518, 14'h05ef};
  int ncs [3] = '{1, 2, 16};

  ethernet_stats_counters DUT (.CORE_CLK(CORE_CLK), .RST(RST),
    .RX_STAT(RX_STAT), .TX_STAT(TX_STAT), .RX_LPI(RX_LPI),
    .EEE_EN(EEE_EN), .POWER_STATE(POWER_STATE),
    .FORCE_BAD_CRC(FORCE_BAD_CRC), .MAX_SIZE(MAX_SIZE),
    .TX_DEFER(TX_DEFER), .BYTE_TICK(BYTE_TICK),
    .TX_COLLISION(TX_COLLISION), .STATS(STATS), .TX_ABORT(TX_ABORT));

  stats_far_side far (.CORE_CLK(CORE_CLK), .RX_STAT(RX_STAT),
    .TX_STAT(TX_STAT), .RX_LPI(RX_LPI), .TX_DEFER(TX_DEFER),
    .BYTE_TICK(BYTE_TICK), .TX_COLLISION(TX_COLLISION));

  // Clock and hang limit
  initial
  begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Queue the expected bank only when it differs from the last note
  task automatic note();
    if (e !== prev)
    begin
      q.push_back(e);
      prev = e;
    end
  endtask

  // Monitor: every change of the bank outside rx_lpi_time consumes the oldest note
  always @(posedge CORE_CLK)
  begin
    #1;
    cur = STATS;
    cur.rx_lpi_time = '0;
    if (cur !== last)
    begin
      if (q.size() == 0) chk(cur, last);
      else chk(cur, q.pop_front());
      last = cur;
    end
  end

  task automatic send_rx(input rx_stat_t r);
    if (r.good && !r.filter_fail && !r.overflow)
      if (r.len inside {[LEN_512:LEN_1023]}) e.rx_512_1023++;
      else if (r.len inside {[LEN_1024:LEN_1518]}) e.rx_1024_1518++;
      else if (r.len > LEN_1518) e.rx_gt_1518++;
    note();
    far.rx(r);
  endtask

  task automatic send(input tx_stat_t t, input int nc);
    bit err;
    err = t.fcs_bad | FORCE_BAD_CRC | t.carrier_err | t.late_col | nc == 16;
    if (nc == 16) e.tx_excess_col++;
    note();
    far.col(nc);
    if (nc == 16) chk(W'(TX_ABORT), W'(1));
    if (t.fcs_bad | FORCE_BAD_CRC) e.tx_fcs_err++;
    if (t.carrier_err) e.tx_carrier_err++;
    if (t.late_col) e.tx_late_col++;
    if (err) e.tx_bad_bytes += t.len;
    else if (!t.partial)
    begin
      if (nc == 1) e.tx_single_col++;
      if (nc > 1) e.tx_multi_col++;
      if (t.pause) e.tx_pause++;
      if (!t.flow_ctrl)
      begin
        if (t.len == LEN_64) e.tx_64++;
        case (t.addr)
          ADDR_UCAST: begin e.tx_ucast++; e.tx_ucast_bytes += t.len; end
          ADDR_BCAST: begin e.tx_bcast++; e.tx_bcast_bytes += t.len; end
          default: begin e.tx_mcast++; e.tx_mcast_bytes += t.len; end
        endcase
      end
      if (t.len inside {[LEN_65:LEN_127]}) e.tx_65_127++;
      if (t.len inside {[LEN_128:LEN_255]}) e.tx_128_255++;
      if (t.len inside {[LEN_256:LEN_511]}) e.tx_256_511++;
    end
    note();
    far.tx(t);
  endtask

  // Main sequence
  initial
  begin
    seed = 32'hcf8a;
    {RST, EEE_EN, FORCE_BAD_CRC} = 3'b100;
    POWER_STATE = PWR_NORMAL;
    MAX_SIZE = 14'h000a;
    {e, prev, last} = '0;
    repeat (10) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST = 1'b0;
    foreach (lens[i]) send_rx({4'b1100, lens[i]});
    send_rx({4'b1000, LEN_512});
    send_rx({4'b1110, LEN_512});
    send_rx({4'b1101, LEN_1024});
    EEE_EN = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      POWER_STATE = pwr_t'(p);
      if (p < 3) e.rx_lpi_trans++;
      note();
      far.lpi(3);
    end
    EEE_EN = 1'b0;
    e.rx_lpi_trans = '0;
    note();
    repeat (3) @(negedge CORE_CLK);
    {EEE_EN, POWER_STATE} = {1'b1, PWR_NORMAL};
    e.rx_lpi_trans++;
    note();
    far.lpi(400);
    chk(W'(STATS.rx_lpi_time), W'(2));
    for (int i = 0; i < 12; i++)
    begin
      t = '0;
      {t.done, t.flow_ctrl, t.pause} = {1'b1, i[2], i[3]};
      t.addr = addr_t'(i % 3);
      t.len = LEN_64 + 14'($unsigned($random(seed)) % 460);
      if (i % 4 == 0) t.len = LEN_64;
      if (i % 4 == 1) t.len = (i < 8) ? LEN_65 : LEN_127;
      send(t, 0);
    end
    for (int k = 0; k < 4; k++)
    begin
      t = '0;
      t.done = 1'b1;
      t.len = 14'($unsigned($random(seed)) % 1500);
      {t.fcs_bad, FORCE_BAD_CRC} = {k == 0, k == 1};
      {t.carrier_err, t.late_col} = {k == 2, k == 3};
      send(t, 0);
    end
    FORCE_BAD_CRC = 1'b0;
    foreach (ncs[j]) send({1'b1, 8'h0, LEN_128}, ncs[j]);
    send({1'b1, 1'b1, 7'h0, LEN_128}, 0);
    far.defer(36);
    far.defer(36);
    e.tx_excess_defer++;
    note();
    far.defer(37);
    send({1'b1, 8'h0, LEN_256}, 0);
    repeat (4) @(negedge CORE_CLK);
    chk(W'(q.size()), '0);
    complete_run();
  end
endmodule // ethernet_stats_counters_tb

`default_nettype wire

/* stats_far_side.sv */
// Far-side model: MAC transmit and receive paths and PHY idle signal
`timescale 1ns/10ps
`default_nettype none

module stats_far_side
  import stats_pkg::*;
(
  input  wire logic     CORE_CLK,
  output var  rx_stat_t RX_STAT,
  output var  tx_stat_t TX_STAT,
  output var  logic     RX_LPI,
  output var  logic     TX_DEFER,
  output var  logic     BYTE_TICK,
  output var  logic     TX_COLLISION
);
  // Everything idle from time zero
  initial
  begin
    {RX_STAT, TX_STAT, RX_LPI, TX_DEFER, BYTE_TICK, TX_COLLISION} = '0;
  end

  // One-cycle receive report
  task automatic rx(input rx_stat_t r);
    @(negedge CORE_CLK);
    RX_STAT = r;
    @(negedge CORE_CLK);
    RX_STAT = '0;
  endtask

  // One-cycle transmit report
  task automatic tx(input tx_stat_t t);
    @(negedge CORE_CLK);
    TX_STAT = t;
    @(negedge CORE_CLK);
    TX_STAT = '0;
  endtask

  // Collision pulses with a quiet cycle between them
  task automatic col(input int n);
    repeat (n)
    begin
      @(negedge CORE_CLK);
      TX_COLLISION = 1'b1;
      @(negedge CORE_CLK);
      TX_COLLISION = 1'b0;
    end
  endtask

  // One deferral lasting the given number of byte times
  task automatic defer(input int ticks);
    @(negedge CORE_CLK);
    TX_DEFER = 1'b1;
    repeat (ticks)
    begin
      @(negedge CORE_CLK);
      BYTE_TICK = 1'b1;
      @(negedge CORE_CLK);
      BYTE_TICK = 1'b0;
    end
    TX_DEFER = 1'b0;
    @(negedge CORE_CLK);
  endtask

  // Idle indication high for exactly cyc clock edges
  task automatic lpi(input int cyc);
    @(negedge CORE_CLK);
    RX_LPI = 1'b1;
    repeat (cyc) @(negedge CORE_CLK);
    RX_LPI = 1'b0;
    @(negedge CORE_CLK);
  endtask
endmodule // stats_far_side

`default_nettype wire

/* stats_pkg.sv */
// Shared types and constants for the statistics counter bank
package stats_pkg;
  localparam int          CLK_NS       = 5;
  localparam int          US_NS        = 1000;
  localparam int          US_CYCLES    = US_NS / CLK_NS;
  localparam logic [7:0]  US_LAST      = 8'(US_CYCLES - 1);
  localparam logic [13:0] LEN_64       = 14'h0040;
  localparam logic [13:0] LEN_65       = 14'h0041;
  localparam logic [13:0] LEN_127      = 14'h007f;
  localparam logic [13:0] LEN_128      = 14'h0080;
  localparam logic [13:0] LEN_255      = 14'h00ff;
  localparam logic [13:0] LEN_256      = 14'h0100;
  localparam logic [13:0] LEN_511      = 14'h01ff;
  localparam logic [13:0] LEN_512      = 14'h0200;
  localparam logic [13:0] LEN_1023     = 14'h03ff;
  localparam logic [13:0] LEN_1024     = 14'h0400;
  localparam logic [13:0] LEN_1518     = 14'h05ee;
  localparam logic [15:0] DEFER_MARGIN = 16'h0010;
  localparam logic [15:0] DEFER_MAX    = 16'hffff;
  localparam logic [4:0]  COL_LIMIT    = 5'h10;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SLEEP0 = 2'b01,
    PWR_SLEEP3 = 2'b10,
    PWR_OTHER  = 2'b11
  } pwr_t;

  typedef enum logic [1:0] {
    ADDR_UCAST = 2'b00,
    ADDR_BCAST = 2'b01,
    ADDR_MCAST = 2'b10
  } addr_t;

  // Receive frame report, valid when done is high
  typedef struct packed {
    logic        done;
    logic        good;
    logic        filter_fail;
    logic        overflow;
    logic [13:0] len;
  } rx_stat_t;

  // Transmit attempt report, valid when done is high
  typedef struct packed {
    logic        done;
    logic        partial;
    logic        fcs_bad;
    logic        carrier_err;
    logic        late_col;
    logic        pause;
    logic        flow_ctrl;
    addr_t       addr;
    logic [13:0] len;
  } tx_stat_t;

  typedef struct packed {
    logic [19:0] rx_512_1023;
    logic [19:0] rx_1024_1518;
    logic [19:0] rx_gt_1518;
    logic [31:0] rx_lpi_trans;
    logic [31:0] rx_lpi_time;
    logic [19:0] tx_fcs_err;
    logic [19:0] tx_excess_defer;
    logic [19:0] tx_carrier_err;
    logic [31:0] tx_bad_bytes;
    logic [19:0] tx_single_col;
    logic [19:0] tx_multi_col;
    logic [19:0] tx_excess_col;
    logic [19:0] tx_late_col;
    logic [31:0] tx_ucast_bytes;
    logic [31:0] tx_bcast_bytes;
    logic [31:0] tx_mcast_bytes;
    logic [19:0] tx_ucast;
    logic [19:0] tx_bcast;
    logic [19:0] tx_mcast;
    logic [19:0] tx_pause;
    logic [19:0] tx_64;
    logic [19:0] tx_65_127;
    logic [19:0] tx_128_255;
    logic [19:0] tx_256_511;
  } stats_t;

  typedef struct packed {
    stats_t      cnt;
    logic        lpi_prev;
    logic [7:0]  us_div;
    logic [15:0] defer_cnt;
    logic        defer_hit;
    logic [4:0]  col_cnt;
    logic        abort;
  } state_t;
endpackage
